//--- oneshot_timer_defs.vh
// register offsets, field positions, codes and reset values of the timer
`ifndef ONESHOT_TIMER_DEFS_VH
`define ONESHOT_TIMER_DEFS_VH

// ----------------------------------------
// register offsets on the plain port
// ----------------------------------------
`define ADDR_PRESCALER 3'h0
`define ADDR_CAPCMP 3'h1
`define ADDR_MODE 3'h2
`define ADDR_OUTCTL 3'h3
`define ADDR_CYCLE 3'h4
`define ADDR_DUTY 3'h5
`define ADDR_COUNTER 3'h6

// ----------------------------------------
// field positions
// ----------------------------------------
`define PRM_CLK_LO 0
`define PRM_CLK_HI 1
`define PRM_ES_LO 4
`define PRM_ES_HI 5
`define CRC_CYC_CAP 0
`define CRC_DUTY_CAP 2
`define TMC_OVF 0
`define TMC_RUN_LO 2
`define TMC_RUN_HI 3
`define TOC_OUT_EN 0
`define TOC_LVR 2
`define TOC_LVS 3
`define TOC_OSP_EN 5
`define TOC_OSPT 6

// ----------------------------------------
// codes, read masks and reset values
// ----------------------------------------
`define RUN_STOP 2'h0
`define RUN_FREE 2'h1
`define RUN_EDGE 2'h2
`define RUN_MATCH 2'h3
`define EDGE_FALL 2'h0
`define EDGE_RISE 2'h1
`define EDGE_NONE 2'h2
`define EDGE_BOTH 2'h3
`define PRM_RD_MASK 16'h0033
`define CRC_RD_MASK 16'h0005
`define TMC_RD_MASK 16'h000D
`define TOC_RD_MASK 16'h0021
`define DIV_MASK0 8'h00
`define DIV_MASK1 8'h03
`define DIV_MASK2 8'h0F
`define DIV_MASK3 8'hFF
`define CNT_MAX 16'hFFFF
`define CNT_ZERO 16'h0000
`define REG_RST 16'h0000

`endif

//--- oneshot_pulse_timer16.v
// 16-bit timer/event counter with one-shot pulse output
//
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "oneshot_timer_defs.vh"

// Notes on behaviour
// - edge-cleared one-shot: valid edge clears, starts; duty match sets, cycle clears
// - duty above cycle swaps roles; equal values are software's fault
// - edge select bits choose rising, falling or both edges of trigger
// - nonzero run mode starts counting at once; 00 stops it
// - start phase vs count clock gives up to one count period error
// - counter reads never lose a count
// - stopped timer neither counts nor raises match pulses
// - compare of 0000H matches on 0000H to 0001H step after wrap
// - compare below count is reached only after overflow
// - level set and level reset bits read as zero
// - software trigger bit clears itself and reads zero
// - one-shot only in free-running or edge-cleared mode
// - trigger edge still restarts counter in software one-shot mode
// - overflow flag set on FFFFH to 0000H step, cycle FFFFH too
// - clearing overflow flag before count reaches 0001H is undone
// - capture beats read and write of the capture register
// - software trigger bit clears, starts counter and runs pulse
module oneshot_pulse_timer16 (
    input wire mclk,
    input wire srst,
    input wire [2:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata,
    input wire trigger_input,
    input wire second_capture_input,
    output reg pulse_output,
    output reg match_irq_cycle,
    output reg match_irq_duty
);

    // ----------------------------------------
    // edge decode
    // ----------------------------------------
    // valid edge of a filtered level under a two-bit edge selection
    function valid_edge;
        input prev;
        input cur;
        input [1:0] sel;
        begin
            if (sel == `EDGE_RISE) begin
                valid_edge = cur & ~prev;
            end else if (sel == `EDGE_FALL) begin
                valid_edge = prev & ~cur;
            end else if (sel == `EDGE_BOTH) begin
                valid_edge = prev ^ cur;
            end else begin
                valid_edge = 1'b0;
            end
        end
    endfunction

    // ----------------------------------------
    // state
    // ----------------------------------------
    reg [15:0] prescaler_reg;
    reg [15:0] capcmp_reg;
    reg [15:0] mode_reg;
    reg [15:0] outctl_reg;
    reg [15:0] cycle_reg;
    reg [15:0] duty_reg;
    reg [15:0] count_reg;
    reg [7:0] div_reg;
    reg ovf_reg;
    reg ovf_pend_reg;
    reg armed_reg;
    reg level_reg;
    reg t_s1_reg;
    reg t_s2_reg;
    reg t_s3_reg;
    reg t_lvl_reg;
    reg t_old_reg;
    reg c_s1_reg;
    reg c_s2_reg;
    reg c_s3_reg;
    reg c_lvl_reg;
    reg c_old_reg;

    reg [15:0] count_next;
    reg [15:0] cycle_next;
    reg [15:0] duty_next;
    reg ovf_next;
    reg armed_next;
    reg level_next;
    reg [15:0] rdata_next;
    reg [7:0] div_mask;

    wire [1:0] run_mode;
    wire [1:0] edge_sel;
    wire run;
    wire cap_cyc;
    wire cap_duty;
    wire osp_mode;
    wire wr_outctl;
    wire sw_fire;
    wire trig_edge;
    wire cap_edge;
    wire restart;
    wire tick;
    wire cyc_hit;
    wire duty_hit;
    wire set_hit;
    wire clr_hit;
    wire wrap;
    wire cap_cyc_ev;
    wire cap_duty_ev;

    assign run_mode = mode_reg[`TMC_RUN_HI:`TMC_RUN_LO];
    assign edge_sel = prescaler_reg[`PRM_ES_HI:`PRM_ES_LO];
    assign run = (run_mode != `RUN_STOP);
    assign cap_cyc = capcmp_reg[`CRC_CYC_CAP];
    assign cap_duty = capcmp_reg[`CRC_DUTY_CAP];

    // ----------------------------------------
    // pin synchronisers and noise filter
    // ----------------------------------------
    // a level is taken only once stages two and three agree
    always @(posedge mclk) begin
        if (srst) begin
            t_s1_reg <= 1'b0;
            t_s2_reg <= 1'b0;
            t_s3_reg <= 1'b0;
            t_lvl_reg <= 1'b0;
            t_old_reg <= 1'b0;
            c_s1_reg <= 1'b0;
            c_s2_reg <= 1'b0;
            c_s3_reg <= 1'b0;
            c_lvl_reg <= 1'b0;
            c_old_reg <= 1'b0;
        end else begin
            t_s1_reg <= trigger_input;
            t_s2_reg <= t_s1_reg;
            t_s3_reg <= t_s2_reg;
            if (t_s2_reg == t_s3_reg) begin
                t_lvl_reg <= t_s3_reg;
            end
            t_old_reg <= t_lvl_reg;
            c_s1_reg <= second_capture_input;
            c_s2_reg <= c_s1_reg;
            c_s3_reg <= c_s2_reg;
            if (c_s2_reg == c_s3_reg) begin
                c_lvl_reg <= c_s3_reg;
            end
            c_old_reg <= c_lvl_reg;
        end
    end

    // ----------------------------------------
    // prescaler
    // ----------------------------------------
    // free-running divider: a start lands at any phase of it,
    // so the first match may come up to one count period late
    always @* begin
        if (prescaler_reg[`PRM_CLK_HI:`PRM_CLK_LO] == 2'h0) begin
            div_mask = `DIV_MASK0;
        end else if (prescaler_reg[`PRM_CLK_HI:`PRM_CLK_LO] == 2'h1) begin
            div_mask = `DIV_MASK1;
        end else if (prescaler_reg[`PRM_CLK_HI:`PRM_CLK_LO] == 2'h2) begin
            div_mask = `DIV_MASK2;
        end else begin
            div_mask = `DIV_MASK3;
        end
    end

    always @(posedge mclk) begin
        if (srst) begin
            div_reg <= 8'h00;
        end else begin
            div_reg <= div_reg + 8'h01;
        end
    end

    assign tick = run && ((div_reg & div_mask) == div_mask);

    // ----------------------------------------
    // triggers, matches and captures
    // ----------------------------------------
    // one-shot is refused in clear-on-match mode: it overflows only with cycle FFFFH
    assign osp_mode = outctl_reg[`TOC_OSP_EN] &&
        (run_mode == `RUN_FREE || run_mode == `RUN_EDGE);
    assign wr_outctl = reg_wr && (reg_addr == `ADDR_OUTCTL);
    assign sw_fire = wr_outctl && reg_wdata[`TOC_OSPT] &&
        osp_mode;
    assign trig_edge = run && valid_edge(t_old_reg, t_lvl_reg,
        edge_sel);
    assign cap_edge = run && valid_edge(c_old_reg, c_lvl_reg, edge_sel);
    // the pin restarts the count even when software fires the pulse
    assign restart = sw_fire || (trig_edge &&
        (run_mode == `RUN_EDGE || osp_mode));
    // equality on a tick: the step value to value+1 is the match,
    // so a compare of zero hits on the step 0000H to 0001H
    assign cyc_hit = tick && !restart && !cap_cyc &&
        (count_reg == cycle_reg);
    assign duty_hit = tick && !restart && !cap_duty &&
        (count_reg == duty_reg);
    // lower compare value turns the pulse on, higher one turns it off
    assign set_hit = (duty_reg < cycle_reg) ? duty_hit : cyc_hit;
    assign clr_hit = (duty_reg < cycle_reg) ? cyc_hit : duty_hit;
    assign wrap = tick && !restart && (count_reg == `CNT_MAX);
    // both-edge selection disables capture into the cycle register
    assign cap_cyc_ev = cap_cyc && trig_edge && (edge_sel != `EDGE_BOTH);
    assign cap_duty_ev = cap_duty && cap_edge;

    // ----------------------------------------
    // counter and compare registers
    // ----------------------------------------
    always @* begin
        count_next = count_reg;
        if (!run) begin
            count_next = `CNT_ZERO;
        end else if (restart) begin
            count_next = `CNT_ZERO;
        end else if (tick) begin
            if (run_mode == `RUN_MATCH && cyc_hit) begin
                count_next = `CNT_ZERO;
            end else begin
                count_next = count_reg + 16'h0001;
            end
        end
    end

    // a capture overrides a write in the same cycle
    always @* begin
        cycle_next = cycle_reg;
        duty_next = duty_reg;
        if (cap_cyc_ev) begin
            cycle_next = count_reg;
        end else if (reg_wr && reg_addr == `ADDR_CYCLE) begin
            cycle_next = reg_wdata;
        end
        if (cap_duty_ev) begin
            duty_next = count_reg;
        end else if (reg_wr && reg_addr == `ADDR_DUTY) begin
            duty_next = reg_wdata;
        end
    end

    // ----------------------------------------
    // overflow flag
    // ----------------------------------------
    // pending bit lasts from the wrap until the step to 0001H;
    // a clear in that span is overridden, set always beats clear
    always @* begin
        ovf_next = ovf_reg;
        if (reg_wr && reg_addr == `ADDR_MODE) begin
            ovf_next = reg_wdata[`TMC_OVF];
        end
        if (wrap || ovf_pend_reg) begin
            ovf_next = 1'b1;
        end
    end

    // ----------------------------------------
    // pulse output
    // ----------------------------------------
    // equal compare values let the clear win; software must avoid it
    always @* begin
        armed_next = armed_reg;
        level_next = level_reg;
        if (restart && osp_mode) begin
            armed_next = 1'b1;
        end else if (armed_reg) begin
            if (set_hit) begin
                level_next = 1'b1;
            end
            if (clr_hit) begin
                level_next = 1'b0;
                armed_next = 1'b0;
            end
        end
        if (wr_outctl && reg_wdata[`TOC_LVS]) begin
            level_next = 1'b1;
        end
        if (wr_outctl && reg_wdata[`TOC_LVR]) begin
            level_next = 1'b0;
        end
        if (!run) begin
            armed_next = 1'b0;
        end
    end

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    // the counter is sampled in one clock, counting goes on beside it
    always @* begin
        if (reg_addr == `ADDR_PRESCALER) begin
            rdata_next = prescaler_reg & `PRM_RD_MASK;
        end else if (reg_addr == `ADDR_CAPCMP) begin
            rdata_next = capcmp_reg & `CRC_RD_MASK;
        end else if (reg_addr == `ADDR_MODE) begin
            rdata_next = (mode_reg & `TMC_RD_MASK) |
                {15'h0000, ovf_reg};
        end else if (reg_addr == `ADDR_OUTCTL) begin
            rdata_next = outctl_reg & `TOC_RD_MASK;
        end else if (reg_addr == `ADDR_CYCLE) begin
            rdata_next = cycle_next;
        end else if (reg_addr == `ADDR_DUTY) begin
            rdata_next = duty_next;
        end else if (reg_addr == `ADDR_COUNTER) begin
            rdata_next = count_reg;
        end else begin
            rdata_next = 16'h0000;
        end
    end

    // ----------------------------------------
    // register update
    // ----------------------------------------
    // strobe bits are never stored, so they read back as zero
    always @(posedge mclk) begin
        if (srst) begin
            prescaler_reg <= `REG_RST;
            capcmp_reg <= `REG_RST;
            mode_reg <= `REG_RST;
            outctl_reg <= `REG_RST;
            cycle_reg <= `REG_RST;
            duty_reg <= `REG_RST;
            count_reg <= `CNT_ZERO;
            ovf_reg <= 1'b0;
            ovf_pend_reg <= 1'b0;
            armed_reg <= 1'b0;
            level_reg <= 1'b0;
            reg_rdata <= 16'h0000;
            pulse_output <= 1'b0;
            match_irq_cycle <= 1'b0;
            match_irq_duty <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == `ADDR_PRESCALER) begin
                prescaler_reg <= reg_wdata & `PRM_RD_MASK;
            end
            if (reg_wr && reg_addr == `ADDR_CAPCMP) begin
                capcmp_reg <= reg_wdata & `CRC_RD_MASK;
            end
            if (reg_wr && reg_addr == `ADDR_MODE) begin
                mode_reg <= reg_wdata & `TMC_RD_MASK & 16'hFFFE;
            end
            if (wr_outctl) begin
                outctl_reg <= reg_wdata & `TOC_RD_MASK;
            end
            cycle_reg <= cycle_next;
            duty_reg <= duty_next;
            count_reg <= count_next;
            ovf_reg <= ovf_next;
            if (wrap) begin
                ovf_pend_reg <= 1'b1;
            end else if (tick || !run) begin
                ovf_pend_reg <= 1'b0;
            end
            armed_reg <= armed_next;
            level_reg <= level_next;
            if (reg_rd) begin
                reg_rdata <= rdata_next;
            end else begin
                reg_rdata <= 16'h0000;
            end
            pulse_output <= level_next & outctl_reg[`TOC_OUT_EN];
            // captures also raise the match pulse of their register
            match_irq_cycle <= cyc_hit || cap_cyc_ev;
            match_irq_duty <= duty_hit || cap_duty_ev;
        end
    end

endmodule
`default_nettype wire

//--- oneshot_timer_checker.sv
// checker of register port and pulse output behaviour
`timescale 1ns/10ps
`default_nettype none
`include "oneshot_timer_defs.vh"
module oneshot_timer_checker (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [2:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic trigger_input,
    input wire logic second_capture_input,
    input wire logic pulse_output,
    input wire logic match_irq_cycle,
    input wire logic match_irq_duty
);
    // ----
    // helper state
    // ----
    logic [1:0] run_reg;
    wire logic irq = match_irq_cycle | match_irq_duty;
    wire logic ctl_wr = reg_wr &&
        (reg_addr == `ADDR_OUTCTL || reg_addr == `ADDR_MODE);
    // mirror of run mode, so stop can be told apart from run
    always_ff @(posedge mclk) begin
        if (srst)
            run_reg <= `RUN_STOP;
        else if (reg_wr && reg_addr == `ADDR_MODE)
            run_reg <= reg_wdata[3:2];
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    // ----
    // sequences and assertions
    // ----
    sequence rd_of(a);
        $past(reg_rd) && $past(reg_addr) == a;
    endsequence
    sequence sw_trig;
        reg_wr && reg_addr == `ADDR_OUTCTL && reg_wdata[`TOC_OSPT] &&
        reg_wdata[`TOC_OSP_EN] && (run_reg == `RUN_FREE ||
        run_reg == `RUN_EDGE);
    endsequence
    sequence cnt_read;
        reg_rd && reg_addr == `ADDR_COUNTER;
    endsequence
    a_rdata_idle_zero: assert property (!$past(reg_rd) |->
        reg_rdata == 16'h0000) else $error("read data outside slot");
    a_unmapped_zero: assert property (rd_of(3'h7) |->
        reg_rdata == 16'h0000) else $error("unmapped read not zero");
    a_outctl_strobe_zero: assert property (
        rd_of(`ADDR_OUTCTL) |-> (reg_rdata & ~`TOC_RD_MASK) == 16'h0000)
        else $error("strobe bits read nonzero");
    a_mode_readback: assert property (
        rd_of(`ADDR_MODE) |-> reg_rdata[3:2] == run_reg)
        else $error("run mode readback wrong");
    a_stop_count_zero: assert property (
        rd_of(`ADDR_COUNTER) && run_reg == `RUN_STOP &&
        $past(run_reg) == `RUN_STOP && $past(run_reg, 2) == `RUN_STOP
        |-> reg_rdata == 16'h0000) else $error("stopped counter moved");
    a_stopped_quiet: assert property (
        run_reg == `RUN_STOP && $past(run_reg) == `RUN_STOP |-> !irq)
        else $error("match pulse while stopped");
    a_pulse_rise_cause: assert property (
        $rose(pulse_output) && !$past(ctl_wr) |-> irq)
        else $error("pulse rose without match");
    a_pulse_fall_cause: assert property (
        $fell(pulse_output) && !$past(ctl_wr) |-> irq)
        else $error("pulse fell without match");
    a_irq_one_cycle: assert property (
        match_irq_duty |=> !match_irq_duty)
        else $error("duty match pulse too long");
    a_sw_trig_clear: assert property (
        sw_trig ##1 cnt_read |=> reg_rdata <= 16'h0001)
        else $error("software trigger left count");
endmodule
bind oneshot_pulse_timer16 oneshot_timer_checker u_chk (
    .mclk(mclk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .trigger_input(trigger_input),
    .second_capture_input(second_capture_input),
    .pulse_output(pulse_output), .match_irq_cycle(match_irq_cycle),
    .match_irq_duty(match_irq_duty)
);
`default_nettype wire

//--- trigger_source.sv
// trigger pin source standing outside the timer
`timescale 1ns/10ps
`default_nettype none
module trigger_source (
    input wire logic mclk,
    output var logic trigger_input,
    output var logic second_capture_input
);
    // pins idle low and stay steady between frames
    initial begin
        trigger_input = 1'b0;
        second_capture_input = 1'b0;
    end
    // one high level of hold cycles; caller waits out the pulse first
    task automatic toggle(input int hold);
        @(posedge mclk);
        trigger_input <= 1'b1;
        repeat (hold) @(posedge mclk);
        trigger_input <= 1'b0;
    endtask
    // one high level on the capture pin, shaped like a trigger
    task automatic capture_pulse(input int hold);
        @(posedge mclk);
        second_capture_input <= 1'b1;
        repeat (hold) @(posedge mclk);
        second_capture_input <= 1'b0;
    endtask
endmodule
`default_nettype wire

//--- tb_top.sv
// self-checking bench of the one-shot pulse timer
`timescale 1ns/10ps
`default_nettype none
`include "oneshot_timer_defs.vh"
module tb_top;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic [2:0] reg_addr = 3'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    wire logic [15:0] reg_rdata;
    wire logic trigger_input, second_capture_input;
    wire logic pulse_output, match_irq_cycle, match_irq_duty;
    int n_fail = 0;
    int total_checks = 0;
    int cycles = 0;
    int k, cnt, hi;
    logic [15:0] rv, c0;
    logic [15:0] tab [5] = '{16'h0210, 16'h0211, 16'h0202, 16'h0223,
                             16'h0111};
    // ----
    // clock, design and far side
    // ----
    always #4 mclk = ~mclk;
    oneshot_pulse_timer16 u_dut (.mclk(mclk), .srst(srst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .trigger_input(trigger_input),
        .second_capture_input(second_capture_input),
        .pulse_output(pulse_output), .match_irq_cycle(match_irq_cycle),
        .match_irq_duty(match_irq_duty));
    trigger_source u_src (.mclk(mclk), .trigger_input(trigger_input),
        .second_capture_input(second_capture_input));
    // ----
    // tasks
    // ----
    // verdict in one place, used by the main flow and the watchdog
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] exp,
                       input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // entered just after an edge; returns 1 ns after the strobe edge,
    // so strobes may follow with no gap
    task automatic bus(input logic w, input logic [2:0] a,
                       input logic [15:0] d);
        reg_wr <= w;
        reg_rd <= ~w;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1;
        rv = reg_rdata;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // count rises and high cycles of the pulse over n cycles
    task automatic watch(input int n);
        logic last;
        last = pulse_output;
        cnt = 0;
        hi = 0;
        repeat (n) begin
            idle(1);
            if (pulse_output === 1'b1)
                hi++;
            if (pulse_output === 1'b1 && last !== 1'b1)
                cnt++;
            last = pulse_output;
        end
    endtask
    // watchdog: the run needs about 66350 cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 90000) begin
            n_fail++;
            complete_run();
        end
    end
    // ----
    // main sequence
    // ----
    initial begin
        repeat (3) @(posedge mclk);
        srst <= 1'b0;
        idle(1);
        for (k = 0; k < 8; k++) begin
            bus(0, k[2:0], 16'h0000);
            chk("reset value", 16'h0000, rv);
        end
        bus(1, `ADDR_OUTCTL, 16'h004D);
        bus(0, `ADDR_OUTCTL, 16'h0000);
        chk("outctl read", 16'h0001, rv);
        bus(1, `ADDR_MODE, 16'h0004);
        bus(0, `ADDR_MODE, 16'h0000);
        chk("mode read", 16'h0004, rv);
        bus(0, `ADDR_COUNTER, 16'h0000);
        c0 = rv;
        idle(2);
        bus(0, `ADDR_COUNTER, 16'h0000);
        chk("count step", 16'h0003, rv - c0);
        bus(1, `ADDR_MODE, 16'h0000);
        u_src.toggle(10);
        idle(10);
        bus(0, `ADDR_COUNTER, 16'h0000);
        chk("stopped count", 16'h0000, rv);
        // software one-shot, duty below and above cycle
        bus(1, `ADDR_OUTCTL, 16'h0021);
        bus(1, `ADDR_MODE, 16'h0004);
        for (k = 0; k < 2; k++) begin
            bus(1, `ADDR_CYCLE, k ? 16'h0003 : 16'h0008);
            bus(1, `ADDR_DUTY, k ? 16'h0008 : 16'h0003);
            bus(1, `ADDR_OUTCTL, 16'h0061);
            bus(0, `ADDR_COUNTER, 16'h0000);
            chk("trigger clear", 16'h0000, rv);
            watch(40);
            chk("pulse count", 16'h0001, cnt[15:0]);
            chk("pulse width", 16'h0005, hi[15:0]);
            bus(0, `ADDR_OUTCTL, 16'h0000);
            chk("trigger bit", 16'h0021, rv);
        end
        // external edges: mode, edge code, expected pulses per entry
        for (k = 0; k < 5; k++) begin
            bus(1, `ADDR_MODE, 16'h0000);
            bus(1, `ADDR_PRESCALER, {10'h000, tab[k][1:0], 4'h0});
            bus(1, `ADDR_MODE, {12'h000, tab[k][9:8], 2'h0});
            fork
                u_src.toggle(40);
                watch(120);
            join
            chk("edge pulses", {12'h000, tab[k][7:4]}, cnt[15:0]);
            chk("edge width", 16'h0005 * tab[k][7:4], hi[15:0]);
        end
        // clear-on-match mode: count runs 0..4 and starts over
        bus(1, `ADDR_MODE, 16'h0000);
        bus(1, `ADDR_CYCLE, 16'h0004);
        bus(1, `ADDR_MODE, 16'h000C);
        idle(6);
        bus(0, `ADDR_COUNTER, 16'h0000);
        chk("match restart", 16'h0001, rv);
        // capture of the count into duty on the second pin's edge;
        // the filter delay is only bounded, so a window is checked
        bus(1, `ADDR_MODE, 16'h0000);
        bus(1, `ADDR_CAPCMP, 16'h0004);
        bus(1, `ADDR_MODE, 16'h0004);
        idle(20);
        bus(0, `ADDR_COUNTER, 16'h0000);
        c0 = rv;
        u_src.capture_pulse(10);
        idle(10);
        bus(0, `ADDR_DUTY, 16'h0000);
        chk("capture window", 16'h0001,
            {15'h0000, rv > c0 && rv < c0 + 16'h000A});
        // wrap with cycle value at the top sets the overflow flag;
        // a clear on the step to 0001H is undone, a later one holds
        bus(1, `ADDR_MODE, 16'h0000);
        bus(1, `ADDR_CYCLE, `CNT_MAX);
        bus(1, `ADDR_MODE, 16'h0004);
        idle(65536);
        bus(1, `ADDR_MODE, 16'h0004);
        bus(0, `ADDR_MODE, 16'h0000);
        chk("overflow kept", 16'h0005, rv);
        bus(1, `ADDR_MODE, 16'h0004);
        bus(0, `ADDR_MODE, 16'h0000);
        chk("overflow clear", 16'h0004, rv);
        complete_run();
    end
endmodule
`default_nettype wire
